// ==== src/atims_pkg.sv ====
// atims_pkg: constants for the trigger front end and mode select
// assumes a 250 MHz core clock and synchronous-to-clock use of the counts
package atims_pkg;
	localparam int CLK_MHZ = 250;
	localparam int ONE_SHOT_MS = 100;
	localparam int ONE_SHOT_CYCLES = ONE_SHOT_MS * 1000 * CLK_MHZ;
	localparam int POWER_UP_MS = 1500;
	localparam int POWER_UP_CYCLES = POWER_UP_MS * 1000 * CLK_MHZ;
	localparam int SYNC_STAGES = 2;
	localparam logic [3:0] SW_CONTINUOUS = 4'h0;
	localparam logic [3:0] SW_PRESET_MAX = 4'h9;
	localparam logic [3:0] SW_PULSE_WIDTH = 4'h9;
	localparam logic [7:0] EXPOSE_LINES_MAX = 8'hff;
	typedef enum logic [2:0] {
		ATIMS_CONTINUOUS = 3'b001,
		ATIMS_PRESET = 3'b010,
		ATIMS_PULSE_WIDTH = 3'b100
	} atims_mode_type;
	typedef enum logic [2:0] {
		ATIMS_PW_IDLE = 3'b001,
		ATIMS_PW_LOW = 3'b010,
		ATIMS_PW_DONE = 3'b100
	} atims_pw_type;
endpackage

// ==== src/atims_trigger_front.sv ====
// atims_trigger_front: merges both shutter triggers, detects trailing edges,
// selects exposure mode, measures pulse width, drives the status indicator.
// assumes trigger pins are raw asynchronous levels; line pulse is synchronous.
`timescale 1ns/10ps
module atims_trigger_front #(
	parameter int ONE_SHOT_CYCLES = atims_pkg::ONE_SHOT_CYCLES,
	parameter int POWER_UP_CYCLES = atims_pkg::POWER_UP_CYCLES,
	parameter int LINE_W = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic power_port_trigger_n_i,
	input wire logic link_trigger_i,
	input wire logic link_invert_i,
	input wire logic pulse_width_exposure_select_i,
	input wire logic [3:0] shutter_switch_i,
	input wire logic internal_line_pulse_i,
	output logic async_mode_o,
	output logic preset_mode_o,
	output logic pulse_width_mode_o,
	output logic expose_start_o,
	output logic expose_lines_valid_o,
	output logic [LINE_W-1:0] expose_lines_o,
	output logic led_red_o,
	output logic led_green_o,
	output logic led_orange_o
);
	logic [atims_pkg::SYNC_STAGES-1:0] pwr_sync_reg;
	logic [atims_pkg::SYNC_STAGES-1:0] lnk_sync_reg;
	logic merged_reg;
	logic line_reg;
	logic trail;
	logic line_trail;
	logic link_active_n;
	logic merged_next;
	atims_pkg::atims_mode_type mode_reg;
	atims_pkg::atims_mode_type mode_next;
	atims_pkg::atims_pw_type pw_reg;
	logic [LINE_W-1:0] lines_reg;
	logic [31:0] shot_reg;
	logic [31:0] boot_reg;
	logic booted_reg;
	logic red_reg;

	function automatic atims_pkg::atims_mode_type decode_mode(input logic [3:0] sw, input logic pwe);
		if (sw == atims_pkg::SW_CONTINUOUS) begin
			decode_mode = atims_pkg::ATIMS_CONTINUOUS;
		end else if (pwe && sw == atims_pkg::SW_PULSE_WIDTH) begin
			decode_mode = atims_pkg::ATIMS_PULSE_WIDTH;
		end else if (sw <= atims_pkg::SW_PRESET_MAX) begin
			decode_mode = atims_pkg::ATIMS_PRESET;
		end else begin
			decode_mode = atims_pkg::ATIMS_CONTINUOUS;
		end
	endfunction

	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pwr_sync_reg <= '1;
			lnk_sync_reg <= '1;
		end else begin
			pwr_sync_reg <= {pwr_sync_reg[0], power_port_trigger_n_i};
			lnk_sync_reg <= {lnk_sync_reg[0], link_trigger_i};
		end
	end

	// reset value assumes default polarity; link idles low only when inverted
	assign link_active_n = link_invert_i ? ~lnk_sync_reg[1] : lnk_sync_reg[1];
	// low when either is active; power port never inverted
	assign merged_next = pwr_sync_reg[1] & link_active_n;
	assign trail = ~merged_reg & merged_next;
	assign line_trail = line_reg & ~internal_line_pulse_i;
	assign mode_next = decode_mode(shutter_switch_i, pulse_width_exposure_select_i);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			merged_reg <= 1'b1;
			line_reg <= 1'b0;
			mode_reg <= atims_pkg::ATIMS_CONTINUOUS;
		end else begin
			merged_reg <= merged_next;
			line_reg <= internal_line_pulse_i;
			mode_reg <= mode_next;
		end
	end

	assign async_mode_o = (mode_reg != atims_pkg::ATIMS_CONTINUOUS);
	assign preset_mode_o = (mode_reg == atims_pkg::ATIMS_PRESET);
	assign pulse_width_mode_o = (mode_reg == atims_pkg::ATIMS_PULSE_WIDTH);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			expose_start_o <= 1'b0;
		end else begin
			expose_start_o <= trail && preset_mode_o;
		end
	end

	// width counted on line edges while merged trigger is low; saturates
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pw_reg <= atims_pkg::ATIMS_PW_IDLE;
			lines_reg <= '0;
			expose_lines_o <= '0;
			expose_lines_valid_o <= 1'b0;
		end else begin
			expose_lines_valid_o <= 1'b0;
			case (pw_reg)
				atims_pkg::ATIMS_PW_IDLE: begin
					lines_reg <= '0;
					if (pulse_width_mode_o && !merged_reg) begin
						pw_reg <= atims_pkg::ATIMS_PW_LOW;
					end
				end
				atims_pkg::ATIMS_PW_LOW: begin
					if (line_trail && lines_reg != {LINE_W{1'b1}}) begin
						lines_reg <= lines_reg + 1'b1;
					end
					if (trail) begin
						pw_reg <= atims_pkg::ATIMS_PW_DONE;
					end
				end
				atims_pkg::ATIMS_PW_DONE: begin
					expose_lines_o <= (lines_reg == '0) ? {{(LINE_W-1){1'b0}}, 1'b1} : lines_reg;
					expose_lines_valid_o <= 1'b1;
					pw_reg <= atims_pkg::ATIMS_PW_IDLE;
				end
				default: begin
					pw_reg <= atims_pkg::ATIMS_PW_IDLE;
				end
			endcase
		end
	end

	// retriggerable one-shot on trailing edges only
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shot_reg <= '0;
			red_reg <= 1'b0;
		end else if (trail && async_mode_o) begin
			shot_reg <= 32'(ONE_SHOT_CYCLES - 1);
			red_reg <= 1'b1;
		end else if (shot_reg != '0) begin
			shot_reg <= shot_reg - 32'h1;
		end else begin
			red_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			boot_reg <= '0;
			booted_reg <= 1'b0;
		end else if (!booted_reg) begin
			boot_reg <= boot_reg + 32'h1;
			booted_reg <= (boot_reg == 32'(POWER_UP_CYCLES - 1));
		end
	end

	assign led_red_o = red_reg;
	assign led_green_o = booted_reg && !red_reg;
	assign led_orange_o = !booted_reg && !red_reg;

	a_red_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(trail && async_mode_o) |=> led_red_o && shot_reg == 32'(ONE_SHOT_CYCLES - 1))
		else $error("one-shot not started on trailing edge");
	a_red_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(shot_reg > 32'h1 && !(trail && async_mode_o)) |=> led_red_o && shot_reg == $past(shot_reg) - 32'h1)
		else $error("one-shot did not count down while lit");
	a_no_edge_stuck: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(!pwr_sync_reg[1]) |-> !trail)
		else $error("trailing edge while power trigger held active");
	a_merge_or: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(!pwr_sync_reg[1] || !link_active_n) |=> !merged_reg)
		else $error("merged trigger not active");
	a_continuous: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(shutter_switch_i == atims_pkg::SW_CONTINUOUS) |=> !async_mode_o ##1 !expose_start_o)
		else $error("switch zero not continuous");
	a_pw_select: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(pulse_width_exposure_select_i && shutter_switch_i == atims_pkg::SW_PULSE_WIDTH) |=> pulse_width_mode_o)
		else $error("pulse width mode not selected");
	a_preset_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(trail && preset_mode_o) |=> expose_start_o)
		else $error("preset exposure not started");
	a_red_priority: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		led_red_o |-> !led_green_o && !led_orange_o)
		else $error("green shown over red");
	a_pw_result: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(pw_reg == atims_pkg::ATIMS_PW_DONE) |=> expose_lines_valid_o && expose_lines_o != '0)
		else $error("pulse width result missing");
	a_boot_green: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$rose(booted_reg) |-> boot_reg == 32'(POWER_UP_CYCLES))
		else $error("green at wrong time");
	a_red_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(shot_reg == 32'h0 && !(trail && async_mode_o)) |=> !led_red_o)
		else $error("one-shot lit past its period");
	a_red_async: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(trail && !async_mode_o && !led_red_o) |=> !led_red_o)
		else $error("red lit in continuous mode");
	a_link_stuck: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(!link_active_n) |-> !trail)
		else $error("trailing edge while link trigger held active");
endmodule

// ==== testbench/atims_trig_src.sv ====
// atims_trig_src: far-side model driving both shutter trigger pins
// assumes the bench calls its tasks; pins move only at falling clock edges
`timescale 1ns/10ps
module atims_trig_src (
	input wire logic clk_i,
	output logic power_n_o,
	output logic link_o
);
	initial begin
		power_n_o = 1'b1;
		link_o = 1'b1;
	end
	// toggling the link pin suits either polarity setting
	task automatic pulse(input bit on_link, input int n);
		@(negedge clk_i);
		if (on_link) link_o = ~link_o;
		else power_n_o = 1'b0;
		repeat (n) @(negedge clk_i);
		if (on_link) link_o = ~link_o;
		else power_n_o = 1'b1;
	endtask
	task automatic set_link(input logic v);
		@(negedge clk_i);
		link_o = v;
	endtask
endmodule

// ==== testbench/tb_async_trigger_input_mode_select.sv ====
// tb_async_trigger_input_mode_select: scenario bench for the trigger front end
// assumes shortened one-shot and power-up counts handed in as parameters
`timescale 1ns/10ps
module tb_async_trigger_input_mode_select;
	logic clk = 1'b0, arst_n = 1'b0, pp_n, lk, inv = 1'b0, pw = 1'b0, line = 1'b0, seen;
	logic [3:0] sw = 4'h5;
	logic am, pm, pwm, st, lv, red, grn, org;
	logic [7:0] lines;
	int errors = 0;
	int check_count = 0;
	always #2 clk = ~clk;
	atims_trig_src src (.clk_i(clk), .power_n_o(pp_n), .link_o(lk));
	atims_trigger_front #(.ONE_SHOT_CYCLES(50), .POWER_UP_CYCLES(100)) dut (.clk_i(clk), .arst_n_i(arst_n),
		.power_port_trigger_n_i(pp_n), .link_trigger_i(lk), .link_invert_i(inv), .pulse_width_exposure_select_i(pw),
		.shutter_switch_i(sw), .internal_line_pulse_i(line), .async_mode_o(am), .preset_mode_o(pm),
		.pulse_width_mode_o(pwm), .expose_start_o(st), .expose_lines_valid_o(lv), .expose_lines_o(lines),
		.led_red_o(red), .led_green_o(grn), .led_orange_o(org));
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic catch_start();
		seen = 1'b0;
		repeat (12) @(negedge clk) if (st === 1'b1) seen = 1'b1;
	endtask
	task automatic catch_lines();
		seen = 1'b0;
		repeat (12) @(negedge clk) if (lv === 1'b1) seen = 1'b1;
	endtask
	task automatic complete_run();
		if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_power_up();
		check("orange", 8'h01, {7'h0, org});
		repeat (110) @(negedge clk);
		check("green", 8'h01, {7'h0, grn & ~org});
	endtask
	task automatic t_preset();
		for (int k = 0; k < 2; k++) begin
			src.pulse(k[0], 5);
			catch_start();
			check("start", 8'h01, {7'h0, seen});
			check("red_lit", 8'h02, {6'h0, red, grn});
			repeat (50) @(negedge clk);
			check("red_off", 8'h00, {7'h0, red});
		end
		src.pulse(1'b0, 200);
		check("red_long", 8'h00, {7'h0, red});
		repeat (30) @(negedge clk);
		check("red_trail", 8'h01, {7'h0, red});
		repeat (40) @(negedge clk);
		check("red_once", 8'h00, {7'h0, red});
	endtask
	task automatic t_retrigger();
		src.pulse(1'b0, 3);
		repeat (30) @(negedge clk);
		src.pulse(1'b0, 3);
		repeat (40) @(negedge clk);
		check("red_ext", 8'h01, {7'h0, red});
		repeat (30) @(negedge clk);
		check("red_end", 8'h00, {7'h0, red});
	endtask
	task automatic t_block();
		src.set_link(1'b0);
		src.pulse(1'b0, 5);
		catch_start();
		check("blocked", 8'h00, {7'h0, seen});
		src.set_link(1'b1);
		catch_start();
		check("released", 8'h01, {7'h0, seen});
	endtask
	task automatic t_invert();
		src.set_link(1'b0);
		inv = 1'b1;
		repeat (20) @(negedge clk);
		src.pulse(1'b1, 5);
		catch_start();
		check("inv_link", 8'h01, {7'h0, seen});
		src.pulse(1'b0, 5);
		catch_start();
		check("inv_power", 8'h01, {7'h0, seen});
		src.set_link(1'b1);
		inv = 1'b0;
		repeat (20) @(negedge clk);
	endtask
	task automatic t_modes();
		logic [7:0] want;
		for (int p = 0; p < 2; p++) for (int s = 0; s < 12; s++) begin
			@(negedge clk);
			pw = p[0];
			sw = s[3:0];
			repeat (3) @(negedge clk);
			want = {5'h0, s inside {[1:9]}, s inside {[1:9]} && !(p == 1 && s == 9), p == 1 && s == 9};
			check("modes", want, {5'h0, am, pm, pwm});
		end
		src.pulse(1'b0, 5);
		catch_start();
		check("cont_start", 8'h00, {7'h0, seen});
		check("cont_red", 8'h00, {7'h0, red});
	endtask
	task automatic t_pulse_width();
		// three line falls kept well inside the low time, so sync lag cannot shift the count
		@(negedge clk);
		sw = 4'h9;
		fork
			src.pulse(1'b0, 40);
			begin
				repeat (4) @(negedge clk);
				repeat (3) begin
					line = 1'b1;
					repeat (4) @(negedge clk);
					line = 1'b0;
					repeat (4) @(negedge clk);
				end
			end
		join
		catch_lines();
		check("lines_valid", 8'h01, {7'h0, seen});
		check("lines", 8'h03, lines);
		src.pulse(1'b0, 3);
		catch_lines();
		check("short_valid", 8'h01, {7'h0, seen});
		check("lines_min", 8'h01, lines);
	endtask
	initial begin
		repeat (16) @(negedge clk);
		arst_n = 1'b1;
		t_power_up();
		t_preset();
		t_retrigger();
		t_block();
		t_invert();
		t_modes();
		t_pulse_width();
		complete_run();
	end
	initial begin
		#(20000 * 4);
		errors++;
		complete_run();
	end
endmodule
